/* File: verification/event_far_side.sv */
// far side model: event channels, fault inputs and decoder restart
// assumes the block clock; strobes rest low outside runs
`timescale 1ns/10ps

module event_far_side
(
	input  wire logic       clk_i,      // shared clock
	input  wire logic       rst_i,      // synchronous reset
	input  wire logic       run_i,      // traffic enabled
	output logic [7:0]      event_ch_o, // event strobes
	output logic            fault_a_o,  // fault input a
	output logic            fault_b_o,  // fault input b
	output logic            dec_o       // decoder restart
);
	logic [15:0] state_q; // pattern source, changes every cycle

	// shift register advancing after each edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_q <= 16'hACE1;
		else
			state_q <= {state_q[14:0], state_q[15] ^ state_q[13] ^ state_q[12] ^ state_q[10]};
	end

	assign event_ch_o = run_i ? state_q[7:0] : 8'h00;
	assign fault_a_o  = run_i & state_q[9];
	assign fault_b_o  = run_i & state_q[11];
	assign dec_o      = run_i & state_q[14];
endmodule : event_far_side

/* File: verification/tc_byte_cfg_chk.sv */
// port checker of the byte-mode timer config block
// assumes it is bound onto tc_byte_cfg and sees its ports only
`timescale 1ns/10ps

module tc_byte_cfg_chk
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       ack_o,
	input wire logic       err_o,
	input wire logic       counter_off_i,
	input wire logic [7:0] wave_i,
	input wire logic [7:0] wave_o,
	input wire logic       fault_present_i,
	input wire logic       fault_capture_o,
	input wire logic       ovf_flag_i,
	input wire logic       err_flag_i,
	input wire logic [1:0] ovf_irq_o,
	input wire logic [1:0] err_irq_o,
	input wire logic [7:0] low_event_o,
	input wire logic       restart_o,
	input wire logic [1:0] restart_src_o,
	input wire logic       decoder_restart_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// a taken request is answered on the next edge, for one cycle only
	a_ack_next: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
		else $error("ack not given one cycle after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_no_err: assert property (!err_o)
		else $error("bus error raised");
	// running counter: outputs follow the waveform one cycle late
	a_wave_follow: assert property (!counter_off_i |=> (wave_o == $past(wave_i)))
		else $error("waveform output not following running value");
	a_fault_unit: assert property (fault_capture_o |-> fault_present_i)
		else $error("fault capture without fault unit");
	a_ovf_gated: assert property (!ovf_flag_i |-> (ovf_irq_o == 2'h0))
		else $error("overflow irq without flag");
	a_err_gated: assert property (!err_flag_i |-> (err_irq_o == 2'h0))
		else $error("error irq without flag");
	a_low_upper: assert property (low_event_o[7:4] == 4'h0)
		else $error("unused low event bits set");
	a_restart_hw: assert property (restart_o |-> (restart_src_o != 2'h0))
		else $error("hardware restart while software only");
	a_restart_dec: assert property ((restart_o && restart_src_o == 2'h2) |-> decoder_restart_i)
		else $error("decoder restart without decoder");
endmodule : tc_byte_cfg_chk

/* File: verification/tc_byte_cfg_test.sv */
// self-checking bench of the byte-mode timer config block
// assumes design files compiled first; checker bound from here
`timescale 1ns/10ps

module tc_byte_cfg_test;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, run;
	logic [4:0]  adr_i;
	logic [3:0]  sel_i, high_event_o, low_compare_o, low_capture_o, high_compare_o, high_capture_o;
	logic [31:0] dat_i, dat_o, seed;
	logic        fault_present_i, counter_off_i, fault_input_a_i, fault_input_b_i;
	logic        decoder_restart_i, ovf_flag_i, err_flag_i, trg_flag_i;
	logic        restart_o, fault_capture_o, irq_o;
	logic [7:0]  wave_i, event_ch_i, wave_o, low_event_o, ev_prev, rd, v, c, e;
	logic [1:0]  restart_src_o, ovf_irq_o, err_irq_o, trg_irq_o;
	logic [10:0] x;
	int          failures, compares;

	tc_byte_cfg dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .err_o, .fault_present_i, .counter_off_i, .wave_i, .event_ch_i,
		.fault_input_a_i, .fault_input_b_i, .decoder_restart_i, .ovf_flag_i, .err_flag_i,
		.trg_flag_i, .wave_o, .low_event_o, .high_event_o, .restart_o, .restart_src_o,
		.fault_capture_o, .low_compare_o, .low_capture_o, .high_compare_o, .high_capture_o,
		.ovf_irq_o, .err_irq_o, .trg_irq_o, .irq_o);
	event_far_side far_u (.clk_i, .rst_i, .run_i(run), .event_ch_o(event_ch_i),
		.fault_a_o(fault_input_a_i), .fault_b_o(fault_input_b_i), .dec_o(decoder_restart_i));

	// clock, 25 ns period
	initial
	begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end

	// copy of the strobes one cycle back, for the delay bit
	always @(posedge clk_i) ev_prev <= event_ch_i;

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// expected {restart source, restart, high d..a, low d..a}
	function automatic logic [10:0] route(input logic [7:0] k, input logic fp, input logic [7:0] s);
		logic [3:0] lo;
		logic [3:0] hi;
		logic       r;
		logic [1:0] rs;
		int         n;
		int         a;
		logic       f;
		n = k[2:0];
		a = k[7:5];
		f = fp && (a == 1 || a == 2);
		for (int j = 0; j < 4; j++)
		begin
			lo[j] = s[(n + j) % 8];
			hi[j] = s[(n + j + 4) % 8];
		end
		rs = (a == 1 || a == 2) ? 2'h1 : (a == 4) ? 2'h2 : (a >= 5) ? 2'h3 : 2'h0;
		lo[1] = (a == 6) ? s[n] : lo[1];
		r = (a == 4) ? decoder_restart_i : (a >= 5) ? s[n] : 1'h0;
		lo[0] = f ? fault_input_a_i : lo[0];
		lo[1] = f ? fault_input_b_i : lo[1];
		r = f ? (fault_input_a_i | fault_input_b_i) : r;
		lo[2] = (f && a == 2) ? fault_input_a_i : lo[2];
		lo[3] = (f && a == 2) ? fault_input_b_i : lo[3];
		if (!k[3] || a == 0 || a == 7)
			return {2'h0, 9'h000};
		return {rs, r, hi, lo};
	endfunction : route

	// every second bit of a mode byte, from bit b
	function automatic logic [3:0] pick(input logic [7:0] m, input int b);
		return {m[6 + b], m[4 + b], m[2 + b], m[b]};
	endfunction : pick

	task automatic stop_test();
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex)
		begin
			failures++;
			$display("BAD %s exp %h got %h", nm, ex, got);
		end
	endtask : chk

	// one classic wishbone cycle, waits for ack under a bound
	task automatic wb(input logic w, input logic [2:0] i, input logic [7:0] wd, output logic [7:0] r);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i  <= w;
		adr_i <= {i, 2'h0};
		dat_i <= {24'h000000, wd};
		for (n = 0; n < 20 && ack_o !== 1'h1; n++)
			@(posedge clk_i);
		if (n == 20)
		begin
			failures++;
			stop_test();
		end
		r = dat_o[7:0];
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i  <= 1'h0;
	endtask : wb

	initial
	begin
		{cyc_i, stb_i, we_i, adr_i, dat_i, fault_present_i, counter_off_i, wave_i, run} = '0;
		{ovf_flag_i, err_flag_i, trg_flag_i} = 3'h0;
		sel_i = 4'hF;
		rst_i = 1'h1;
		seed = 32'h00000060;
		failures = 0;
		compares = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		// reset values of every register except index 1 first, then write and read back every one except indices 1 and 7
		for (int i = 0; i < 8; i++)
		begin
			if (i != 1)
				wb(1'h0, i, 8'h00, rd);
			if (i != 1)
				chk("reset value", 8'h00, rd);
		end
		for (int i = 0; i < 8; i++)
		begin
			v = rnd();
			if (i != 1 && i != 7)
				wb(1'h1, i, v, rd);
			if (i != 1 && i != 7)
				wb(1'h0, i, 8'h00, rd);
			if (i != 1 && i != 7)
				chk("readback", v & (i == 6 ? 8'h3F : i == 0 ? 8'h0F : 8'hFF), rd);
		end
		wb(1'h1, 0, 8'h00, rd);
		wb(1'h1, 7, 8'hFF, rd);
		// interrupt levels, sticky status, mask and clear
		v = rnd();
		wb(1'h1, 6, v, rd);
		{ovf_flag_i, err_flag_i, trg_flag_i} <= 3'h7;
		@(negedge clk_i);
		chk("ovf level", v[1:0], ovf_irq_o);
		chk("err level", v[3:2], err_irq_o);
		chk("trg level", v[5:4], trg_irq_o);
		@(posedge clk_i);
		{ovf_flag_i, err_flag_i, trg_flag_i} <= 3'h0;
		wb(1'h0, 7, 8'h00, rd);
		chk("status", 8'h07, rd & 8'h07);
		chk("irq masked", 1'h0, irq_o);
		wb(1'h1, 0, 8'h02, rd);
		@(negedge clk_i);
		chk("irq", 1'h1, irq_o);
		wb(1'h1, 7, 8'h02, rd);
		wb(1'h0, 7, 8'h00, rd);
		chk("status cleared", 8'h05, rd & 8'h07);
		@(negedge clk_i);
		chk("irq cleared", 1'h0, irq_o);
		// override while stopped, follow while running
		@(posedge clk_i);
		counter_off_i <= 1'h1;
		v = rnd();
		wb(1'h1, 2, v, rd);
		repeat (2) @(negedge clk_i);
		chk("override", v, wave_o);
		wb(1'h0, 1, 8'h00, rd);
		chk("observe", v, rd);
		counter_off_i <= 1'h0;
		wave_i <= rnd();
		repeat (2) @(negedge clk_i);
		chk("running wave", wave_i, wave_o);
		// channel modes, all four codes, fault unit fitted
		@(posedge clk_i);
		fault_present_i <= 1'h1;
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 8'h1B : (i == 1) ? 8'hE4 : rnd();
			wb(1'h1, 4, v, rd);
			wb(1'h1, 5, ~v, rd);
			@(negedge clk_i);
			chk("low compare", pick(v, 0), low_compare_o);
			chk("low capture", pick(v, 1), low_capture_o);
			chk("high compare", pick(~v, 0), high_compare_o);
			chk("high capture", pick(~v, 1), high_capture_o);
		end
		// every action, reserved and valid sources, delay bit
		@(posedge clk_i);
		run <= 1'h1;
		for (int i = 0; i < 32; i++)
		begin
			v = rnd();
			c = {i[2:0], 1'h0, v[3] | v[4], v[2:0]};
			c[4] = i[4] && (i[2:0] != 1) && (i[2:0] != 2);
			@(posedge clk_i);
			fault_present_i <= i[3];
			wb(1'h1, 3, c, rd);
			repeat (6)
			begin
				@(negedge clk_i);
				e = c[4] ? ev_prev : event_ch_i;
				x = route(c, i[3], e);
				chk("routing", x[8:0], {restart_o, high_event_o, low_event_o[3:0]});
				chk("restart src", x[10:9], restart_src_o);
				chk("fault capture", c[3] && i[3] && (i[2:0] == 1 || i[2:0] == 2), fault_capture_o);
			end
		end
		// last action written is reserved: its status bit survives a clear
		wb(1'h1, 7, 8'hFF, rd);
		wb(1'h0, 7, 8'h00, rd);
		chk("reserved flag", 8'h08, rd & 8'h08);
		stop_test();
	end
endmodule : tc_byte_cfg_test

bind tc_byte_cfg tc_byte_cfg_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .err_o,
	.counter_off_i, .wave_i, .wave_o, .fault_present_i, .fault_capture_o, .ovf_flag_i,
	.err_flag_i, .ovf_irq_o, .err_irq_o, .low_event_o, .restart_o, .restart_src_o,
	.decoder_restart_i);

/* File: verilog/channel_mode_decode.sv */
// decodes one 2-bit channel mode field into compare and capture enables
// assumes the mode field comes straight from a register
`timescale 1ns/10ps

module channel_mode_decode
(
	input  wire logic [1:0] mode_i,    // channel mode code
	input  wire logic       enable_i,  // channel allowed to act
	output logic            compare_o, // output compare enabled
	output logic            capture_o  // input capture enabled
);

	// bit 0 enables compare, bit 1 capture; both set means combined
	always_comb
	begin
		compare_o = enable_i & mode_i[0];
		capture_o = enable_i & mode_i[1];
	end

endmodule : channel_mode_decode

/* File: verilog/tc_byte_cfg.sv */
// configuration logic of a 16-bit timer in split 8-bit mode: output override,
// event action and source routing, channel modes, interrupt levels
// assumes a classic wishbone master, event channels and fault inputs on clk_i
//
// Summary of operation
// R1 - override byte sets outputs while counter off
// R2 - event action field decoded, code 111 reserved
// R3 - without fault unit, fault actions plain capture
// R4 - delay bit delays selected event one clock
// R5 - source 0000 none, 0xxx reserved, 1nnn channel
// R6 - source acts only with action not none
// R7 - default low routing n, n+1, n+2, n+3
// R8 - fault and pulse-width alter low channel sources
// R9 - high channels always take n+4 to n+7
// R10 - restart source follows event action
// R11 - low channel two-bit mode fields decoded
// R12 - high channel mode fields decoded alike
// R13 - software uses combined mode only with fault
// R14 - overflow irq at level, zero disables
// R15 - error irq at level, zero disables
// R16 - reserved codes yield no routing or restart
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
`include "tc_byte_cfg_regs.svh"

module tc_byte_cfg
(
	input  wire logic       clk_i,           // peripheral clock, 40 MHz
	input  wire logic       rst_i,           // synchronous reset, active high
	input  wire logic       cyc_i,           // wishbone cycle
	input  wire logic       stb_i,           // wishbone strobe
	input  wire logic       we_i,            // wishbone write enable
	input  wire logic [4:0] adr_i,           // wishbone byte address
	input  wire logic [3:0] sel_i,           // wishbone byte selects
	input  wire logic [31:0] dat_i,          // wishbone write data
	output logic [31:0]     dat_o,           // wishbone read data
	output logic            ack_o,           // wishbone acknowledge
	output logic            err_o,           // wishbone error, unmapped
	input  wire logic       fault_present_i, // fault extension fitted
	input  wire logic       counter_off_i,   // counter stopped
	input  wire logic [7:0] wave_i,          // running waveform outputs
	input  wire logic [7:0] event_ch_i,      // event channel strobes
	input  wire logic       fault_input_a_i, // fault input a
	input  wire logic       fault_input_b_i, // fault input b
	input  wire logic       decoder_restart_i, // quadrature decoder restart
	input  wire logic       ovf_flag_i,      // overflow flag pulse
	input  wire logic       err_flag_i,      // error flag pulse
	input  wire logic       trg_flag_i,      // trigger flag pulse
	output logic [7:0]      wave_o,          // waveform outputs
	output logic [7:0]      low_event_o,     // low channel d..a events (upper 4 bits unused)
	output logic [3:0]      high_event_o,    // high channel d..a events
	output logic            restart_o,       // hardware restart pulse
	output logic [1:0]      restart_src_o,   // restart source class
	output logic            fault_capture_o, // fault-mode capture active
	output logic [3:0]      low_compare_o,   // low channel compare enables
	output logic [3:0]      low_capture_o,   // low channel capture enables
	output logic [3:0]      high_compare_o,  // high channel compare enables
	output logic [3:0]      high_capture_o,  // high channel capture enables
	output logic [1:0]      ovf_irq_o,       // overflow irq level, zero none
	output logic [1:0]      err_irq_o,       // error irq level, zero none
	output logic [1:0]      trg_irq_o,       // trigger irq level, zero none
	output logic            irq_o            // summary interrupt, level
);

	// registers
	logic [7:0] override_q;        // output override byte
	logic [7:0] event_ctrl_q;      // event control
	logic [7:0] low_mode_q;        // low channel modes
	logic [7:0] high_mode_q;       // high channel modes
	logic [7:0] irq_level_q;       // interrupt levels
	logic [7:0] status_q;          // sticky event status
	logic [7:0] mask_q;            // status mask
	logic [7:0] event_dly_q;       // delayed event strobes
	logic       ack_q;             // acknowledge flop
	logic       err_q;             // error flop
	logic [31:0] rdata_q;          // read data flop

	// decoded
	tc_byte_cfg_pkg::event_action_type   action;   // effective action
	tc_byte_cfg_pkg::restart_source_type rsrc;     // restart source
	logic [2:0] chan_n;            // selected channel n
	logic       src_valid;         // source selects a channel
	logic       active;            // routing active
	logic [7:0] ev;                // events after optional delay
	logic [7:0] low_ev;            // low events d..a in bits 3..0
	logic       req;               // bus request
	logic [2:0] idx;               // register index
	logic       mapped;            // address decodes
	logic       wr_stb;            // byte 0 write taken this cycle
	logic       cfg_reserved;      // reserved action or source written

	// pick channel (n + k) mod 8 from the event vector
	function automatic logic pick(input logic [7:0] v, input logic [2:0] n,
		input logic [2:0] k);
		logic [2:0] s;
		s = n + k;
		pick = v[s];
	endfunction : pick

	// a write lands on the edge that takes the request; sel_i[0] gates it
	assign req    = cyc_i & stb_i & ~ack_q & ~err_q;
	assign idx    = adr_i[4:2];
	assign mapped = 1'b1;
	assign wr_stb = req & we_i & sel_i[0];

	// field extraction
	assign chan_n    = event_ctrl_q[`EVENT_SOURCE_FIELD_MSB-1:`EVENT_SOURCE_FIELD_LSB];
	assign src_valid = event_ctrl_q[`EVENT_SOURCE_FIELD_MSB];                   // R5

	// effective action: reserved action or source means none
	always_comb
	begin
		action = tc_byte_cfg_pkg::event_action_type'(event_ctrl_q[`EVENT_ACTION_FIELD_MSB:`EVENT_ACTION_FIELD_LSB]); // R2
		if (action == tc_byte_cfg_pkg::ACT_RSVD || !src_valid)
		begin
			action = tc_byte_cfg_pkg::ACT_NONE;                        // R16
		end
	end

	assign active = (action != tc_byte_cfg_pkg::ACT_NONE);         // R6

	// reserved action, or a non-zero source without its channel bit; kept as status bit 3
	assign cfg_reserved = (event_ctrl_q[`EVENT_ACTION_FIELD_MSB:`EVENT_ACTION_FIELD_LSB] == 3'h7) |
		((event_ctrl_q[`EVENT_SOURCE_FIELD_MSB:`EVENT_SOURCE_FIELD_LSB] != 4'h0) & !src_valid);   // R16

	// event delay stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			event_dly_q <= `RST_BYTE;
		else
			event_dly_q <= event_ch_i;
	end

	// choose delayed or direct events
	assign ev = event_ctrl_q[`EVENT_DELAY_BIT_BIT] ? event_dly_q : event_ch_i; // R4

	// low channel routing
	always_comb
	begin
		low_ev = 8'h00;
		if (active)
		begin
			// default pattern
			low_ev[0] = pick(ev, chan_n, 3'h0);                          // R7
			low_ev[1] = pick(ev, chan_n, 3'h1);                          // R7
			low_ev[2] = pick(ev, chan_n, 3'h2);                          // R7
			low_ev[3] = pick(ev, chan_n, 3'h3);                          // R7
			case (action)
				tc_byte_cfg_pkg::ACT_FAULT1:
				begin
					if (fault_present_i)
					begin
						low_ev[0] = fault_input_a_i;                           // R8
						low_ev[1] = fault_input_b_i;                           // R8
					end
				end
				tc_byte_cfg_pkg::ACT_FAULT2:
				begin
					if (fault_present_i)
					begin
						low_ev[0] = fault_input_a_i;                           // R8
						low_ev[1] = fault_input_b_i;                           // R8
						low_ev[2] = fault_input_a_i;                           // R8
						low_ev[3] = fault_input_b_i;                           // R8
					end
				end
				tc_byte_cfg_pkg::ACT_PWF:
				begin
					low_ev[1] = pick(ev, chan_n, 3'h0);                      // R8
				end
				default:
				begin
					low_ev[3:0] = low_ev[3:0];
				end
			endcase
		end
	end

	// high channel routing, the same for every valid action
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_high
			assign high_event_o[g] = active & pick(ev, chan_n, 3'(g + 4)); // R9
		end
	endgenerate

	// without fault unit the fault actions are plain captures
	assign fault_capture_o = fault_present_i & (action == tc_byte_cfg_pkg::ACT_FAULT1 |
		action == tc_byte_cfg_pkg::ACT_FAULT2);                     // R3

	// restart source per action
	always_comb
	begin
		case (action)                                                 // R10
			tc_byte_cfg_pkg::ACT_FAULT1,
			tc_byte_cfg_pkg::ACT_FAULT2:  rsrc = tc_byte_cfg_pkg::RST_SW_FAULT;
			tc_byte_cfg_pkg::ACT_QUADRATURE_DECODE_ACTION:    rsrc = tc_byte_cfg_pkg::RST_DECODER;
			tc_byte_cfg_pkg::ACT_RESTART,
			tc_byte_cfg_pkg::ACT_PWF:     rsrc = tc_byte_cfg_pkg::RST_EVENT;
			default:                      rsrc = tc_byte_cfg_pkg::RST_SOFTWARE;
		endcase
	end

	// hardware restart pulse for low counter; high side restarts by software in fault modes
	always_comb
	begin
		case (rsrc)                                                   // R10
			tc_byte_cfg_pkg::RST_SW_FAULT: restart_o = fault_present_i &
				(fault_input_a_i | fault_input_b_i);
			tc_byte_cfg_pkg::RST_DECODER:  restart_o = decoder_restart_i;
			tc_byte_cfg_pkg::RST_EVENT:    restart_o = pick(ev, chan_n, 3'h0);
			default:                       restart_o = 1'b0;
		endcase
	end

	// source class for the counter; zero means software restart only
	assign restart_src_o = rsrc;
	assign low_event_o   = {4'h0, low_ev[3:0]};

	// channel mode decoders
	// enable tied high: in byte mode every channel may act on its mode field
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_mode
			channel_mode_decode u_low
			(
				.mode_i    (low_mode_q[2*g+1:2*g]),                         // R11
				.enable_i  (1'b1),
				.compare_o (low_compare_o[g]),
				.capture_o (low_capture_o[g])
			);
			channel_mode_decode u_high
			(
				.mode_i    (high_mode_q[2*g+1:2*g]),                        // R12
				.enable_i  (1'b1),
				.compare_o (high_compare_o[g]),
				.capture_o (high_capture_o[g])
			);
		end
	endgenerate

	// waveform outputs: override while off, running values otherwise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wave_o <= `RST_BYTE;
		else if (counter_off_i)
			wave_o <= override_q;                                       // R1
		else
			wave_o <= wave_i;
	end

	// interrupt levels to the priority controller
	assign ovf_irq_o = ovf_flag_i ? irq_level_q[`OVF_LVL_LSB+1:`OVF_LVL_LSB] : 2'h0; // R14
	assign err_irq_o = err_flag_i ? irq_level_q[`ERR_LVL_LSB+1:`ERR_LVL_LSB] : 2'h0; // R15
	assign trg_irq_o = trg_flag_i ? irq_level_q[`TRG_LVL_LSB+1:`TRG_LVL_LSB] : 2'h0;

	// configuration registers written over the bus
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			override_q   <= `RST_BYTE;
			event_ctrl_q <= `RST_BYTE;
			low_mode_q   <= `RST_BYTE;
			high_mode_q  <= `RST_BYTE;
			irq_level_q  <= `RST_BYTE;
			mask_q       <= `RST_BYTE;
		end
		else if (wr_stb)
		begin
			if (idx == `IDX_OUT_OVERRIDE)
				override_q <= dat_i[7:0];                                 // R1
			else if (idx == `IDX_EVENT_CTRL)
				event_ctrl_q <= dat_i[7:0];
			else if (idx == `IDX_LOW_MODE)
				low_mode_q <= dat_i[7:0];
			else if (idx == `IDX_HIGH_MODE)
				high_mode_q <= dat_i[7:0];
			else if (idx == `IDX_IRQ_LEVEL)
				irq_level_q <= dat_i[7:0] & `INTLVL_USED;
			else if (idx == `IDX_IRQ_MASK)
				mask_q <= dat_i[7:0] & `ST_USED;
		end
	end

	// sticky status: overflow, error, trigger, reserved-code; set wins over clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_q <= `RST_BYTE;
		else
		begin
			// new events are or-ed in after the clear, so a set in the same cycle wins
			status_q <= (status_q & ~((wr_stb && idx == `IDX_IRQ_STATUS) ? dat_i[7:0] : 8'h00))
				| {4'h0, cfg_reserved, trg_flag_i, err_flag_i, ovf_flag_i};
		end
	end

	// level interrupt: high while any unmasked status bit is set
	assign irq_o = |(status_q & mask_q);

	// bus answer one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req & mapped;
			err_q <= req & ~mapped;
			// read data captured with the request, stands until the next read
			if (req && !we_i)
			begin
				if (idx == `IDX_OUT_OVERRIDE)
					rdata_q <= {24'h000000, override_q};
				else if (idx == `IDX_EVENT_CTRL)
					rdata_q <= {24'h000000, event_ctrl_q};
				else if (idx == `IDX_LOW_MODE)
					rdata_q <= {24'h000000, low_mode_q};
				else if (idx == `IDX_HIGH_MODE)
					rdata_q <= {24'h000000, high_mode_q};
				else if (idx == `IDX_IRQ_LEVEL)
					rdata_q <= {24'h000000, irq_level_q};
				else if (idx == `IDX_IRQ_STATUS)
					rdata_q <= {24'h000000, status_q};
				else if (idx == `IDX_IRQ_MASK)
					rdata_q <= {24'h000000, mask_q};
				else
					rdata_q <= {24'h000000, wave_o};
			end
		end
	end

	// bus outputs straight from flops, no combinational path from the bus
	assign ack_o = ack_q;
	assign err_o = err_q;
	assign dat_o = rdata_q;

endmodule : tc_byte_cfg

/* File: verilog/tc_byte_cfg_pkg.sv */
// types for the byte-mode timer configuration block
// constants live in tc_byte_cfg_regs.svh
package tc_byte_cfg_pkg;

	// event action codes
	typedef enum logic [2:0] {
		ACT_NONE    = 3'b000,
		ACT_FAULT1  = 3'b001,
		ACT_FAULT2  = 3'b010,
		ACT_EXTERNAL_DIRECTION_COUNT  = 3'b011,
		ACT_QUADRATURE_DECODE_ACTION    = 3'b100,
		ACT_RESTART = 3'b101,
		ACT_PWF     = 3'b110,
		ACT_RSVD    = 3'b111
	} event_action_type;

	// restart source selection
	typedef enum logic [1:0] {
		RST_SOFTWARE = 2'b00,
		RST_SW_FAULT = 2'b01,
		RST_DECODER  = 2'b10,
		RST_EVENT    = 2'b11
	} restart_source_type;

	// per channel source class
	typedef enum logic [1:0] {
		SRC_NONE    = 2'b00,
		SRC_CHANNEL = 2'b01,
		SRC_FAULT_A = 2'b10,
		SRC_FAULT_B = 2'b11
	} channel_source_type;

	// channel mode code
	typedef enum logic [1:0] {
		MODE_DISABLE = 2'b00,
		MODE_COMPARE = 2'b01,
		MODE_CAPTURE = 2'b10,
		MODE_BOTH    = 2'b11
	} channel_mode_type;

	// irq level
	typedef enum logic [1:0] {
		LVL_OFF  = 2'b00,
		LVL_LOW  = 2'b01,
		LVL_MED  = 2'b10,
		LVL_HIGH = 2'b11
	} irq_level_type;

endpackage : tc_byte_cfg_pkg

/* File: verilog/tc_byte_cfg_regs.svh */
// register offsets, field positions, reset values and codes of the byte-mode timer config block
// assumes word-aligned wishbone addressing: byte address = 4 * printed offset
`ifndef TC_BYTE_CFG_REGS_SVH
`define TC_BYTE_CFG_REGS_SVH

// printed offsets (register index)
`define IDX_OUT_OVERRIDE   3'h2
`define IDX_EVENT_CTRL     3'h3
`define IDX_LOW_MODE       3'h4
`define IDX_HIGH_MODE      3'h5
`define IDX_IRQ_LEVEL      3'h6
`define IDX_IRQ_STATUS     3'h7
`define IDX_IRQ_MASK       3'h0
`define IDX_OBSERVE        3'h1

// reset values
`define RST_BYTE           8'h00

// event control fields
`define EVENT_ACTION_FIELD_MSB          7
`define EVENT_ACTION_FIELD_LSB          5
`define EVENT_DELAY_BIT_BIT          4
`define EVENT_SOURCE_FIELD_MSB          3
`define EVENT_SOURCE_FIELD_LSB          0

// interrupt level fields
`define OVF_LVL_LSB        0
`define ERR_LVL_LSB        2
`define TRG_LVL_LSB        4
`define INTLVL_USED        8'h3F

// interrupt status bits
`define ST_OVF_BIT         0
`define ST_ERR_BIT         1
`define ST_TRG_BIT         2
`define ST_RESERVED_BIT    3
`define ST_USED            8'h0F

`endif
